/* File: sfcd_pkg.sv */
/*
  Constants, opcodes, command families and the decoded command carrier for
  the serial flash command decoder.
  Assumes a 10 MHz core clock that oversamples the serial link.
*/
// Summary of operation
// - Ones byte in continuous read exits to standby
// - Program suspend clears busy flag within 40 us
// - Erase suspend clears busy flag within 45 us
// - 03/13 normal reads, 50 MHz ceiling
// - 0B/0C fast reads, 133 MHz ceiling
// - 0D/0E DDR fast reads, 80 MHz ceiling
// - 02/12 page program, 133 MHz ceiling
// - 32/38/34 quad page program, 80 MHz
// - 3B/3C dual output reads, 104 MHz
// - Register write, write enable/disable, register reads
// - 30 clears fail flags, 133 MHz
// - Boot, bank, ECC, protection, pattern, OTP codes
// - Instruction bits sampled on serial clock rise
// - Busy flag high while self-timed operation runs
package sfcd_pkg;

  localparam int CLK_MHZ = 10;
  localparam int PSL_US  = 40;
  localparam int ESL_US  = 45;
  localparam int PSL_CYC = PSL_US * CLK_MHZ;
  localparam int ESL_CYC = ESL_US * CLK_MHZ;
  localparam int TMR_W   = 9;
  // Cycles taken off each suspend count to cover pin sync and commit delay
  localparam int SUSP_LEAD = 8;

  localparam logic [2:0] PIN_RST   = 3'h2;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  localparam logic [7:0] MHZ_50  = 8'h32;
  localparam logic [7:0] MHZ_80  = 8'h50;
  localparam logic [7:0] MHZ_104 = 8'h68;
  localparam logic [7:0] MHZ_133 = 8'h85;

  localparam logic [7:0] OP_WRITE_REGS   = 8'h01;
  localparam logic [7:0] OP_PROG         = 8'h02;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0] OP_READ_ST1     = 8'h05;
  localparam logic [7:0] OP_WRITE_EN     = 8'h06;
  localparam logic [7:0] OP_READ_ST2     = 8'h07;
  localparam logic [7:0] OP_FAST         = 8'h0B;
  localparam logic [7:0] OP_FAST_4B      = 8'h0C;
  localparam logic [7:0] OP_DDR_FAST     = 8'h0D;
  localparam logic [7:0] OP_DDR_FAST_4B  = 8'h0E;
  localparam logic [7:0] OP_PROG_4B      = 8'h12;
  localparam logic [7:0] OP_READ_4B      = 8'h13;
  localparam logic [7:0] OP_BOOT_RD      = 8'h14;
  localparam logic [7:0] OP_BOOT_WR      = 8'h15;
  localparam logic [7:0] OP_BANK_RD      = 8'h16;
  localparam logic [7:0] OP_BANK_WR      = 8'h17;
  localparam logic [7:0] OP_ECC_RD       = 8'h18;
  localparam logic [7:0] OP_PROT_RD      = 8'h2B;
  localparam logic [7:0] OP_PROT_PROG    = 8'h2F;
  localparam logic [7:0] OP_CLEAR_ST     = 8'h30;
  localparam logic [7:0] OP_QPROG_A      = 8'h32;
  localparam logic [7:0] OP_QPROG_4B     = 8'h34;
  localparam logic [7:0] OP_READ_CFG1    = 8'h35;
  localparam logic [7:0] OP_QPROG_B      = 8'h38;
  localparam logic [7:0] OP_DUAL_OUT     = 8'h3B;
  localparam logic [7:0] OP_DUAL_OUT_4B  = 8'h3C;
  localparam logic [7:0] OP_PATTERN_RD   = 8'h41;
  localparam logic [7:0] OP_OTP_PROG     = 8'h42;
  localparam logic [7:0] OP_ERASE_SUSP   = 8'h75;
  localparam logic [7:0] OP_ERASE_RES    = 8'h7A;
  localparam logic [7:0] OP_PROG_SUSP    = 8'h85;
  localparam logic [7:0] OP_PROG_RES     = 8'h8A;
  localparam logic [7:0] OP_MODE_RESET   = 8'hFF;

  typedef enum logic [4:0] {
    FAM_NONE, FAM_READ, FAM_FAST, FAM_DDR, FAM_DUAL, FAM_PROG, FAM_QPROG,
    FAM_REG_WR, FAM_REG_RD, FAM_WEN, FAM_WDIS, FAM_CLEAR, FAM_PSUSP,
    FAM_ESUSP, FAM_PRES, FAM_ERES, FAM_MODE_RST
  } sfcd_family_t;

  typedef enum logic [1:0] {ADDR_NONE, ADDR_3OR4, ADDR_4} sfcd_addr_t;

  typedef struct packed {
    logic [7:0]   opcode;
    sfcd_family_t family;
    sfcd_addr_t   addr;
    logic [7:0]   max_mhz;
  } sfcd_cmd_t;

endpackage : sfcd_pkg

/* File: sfcd_latency_timer.sv */
/*
  Down-counter that times a suspend latency in core clock cycles.
  Assumes load is a one-cycle pulse on the core clock; done pulses once.
*/
`timescale 1ns/100ps
module sfcd_latency_timer
  import sfcd_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] load_val,
  input  wire logic             abort,
  output logic                  done
);

  logic [TMR_W-1:0] count_reg;

  always_ff @(posedge core_clk) begin
    if (srst || abort) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_val;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign done = (count_reg == {{(TMR_W-1){1'b0}}, 1'b1}) && !load && !abort;

endmodule : sfcd_latency_timer

/* File: sfcd_decoder.sv */
/*
  Instruction decode front end of a serial flash: samples the link pins,
  collects the instruction byte, classifies it, handles the mode bit reset
  escape and times program and erase suspend latency on the busy flag.
  Assumes the link pins are asynchronous to core_clk and that the serial
  clock is far slower than core_clk; the read and algorithm engines sit
  on core_clk.
*/
`timescale 1ns/100ps
module sfcd_decoder
  import sfcd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic spi_sck,
  input  wire logic spi_cs_n,
  input  wire logic spi_io0,
  input  wire logic cont_read_enter,
  input  wire logic prog_busy,
  input  wire logic erase_busy,
  input  wire logic alg_paused,
  output sfcd_cmd_t cmd,
  output logic      cmd_valid,
  output logic      cmd_commit,
  output logic      mode_bit_reset_cmd,
  output logic      cont_read_active,
  output logic      prog_suspend_req,
  output logic      erase_suspend_req,
  output logic      write_in_progress_flag
);

  localparam int C_PSL = PSL_CYC;
  localparam int C_ESL = ESL_CYC;

  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_CONT, ST_PASS, ST_IGNORE} sfcd_state_t;

  logic [2:0]  pin_raw;
  logic [2:0]  pin_meta_reg;
  logic [2:0]  pin_sync_reg;
  logic        sck_prev_reg;
  logic        cs_prev_reg;
  logic        sck_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic        si_bit;
  sfcd_state_t state_reg;
  logic [2:0]  bit_cnt_reg;
  logic [6:0]  shift_reg;
  logic [7:0]  byte_next;
  logic        extra_reg;
  logic        cont_mode_reg;
  sfcd_cmd_t   cmd_reg;
  sfcd_cmd_t   cmd_next;
  logic        cmd_valid_reg;
  logic        commit_reg;
  logic        mode_rst_reg;
  logic        psusp_pend_reg;
  logic        psusp_reg;
  logic        esusp_pend_reg;
  logic        esusp_reg;
  logic        wip_reg;
  logic        tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic        tmr_done;
  logic        susp_abort;
  logic        commit_now;

  // Pin synchronisers; only IO0 carries instruction bits
  assign pin_raw = {spi_io0, spi_cs_n, spi_sck};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (srst) begin
          pin_meta_reg[gi] <= PIN_RST[gi];
          pin_sync_reg[gi] <= PIN_RST[gi];
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end else begin
      sck_prev_reg <= pin_sync_reg[0];
      cs_prev_reg  <= pin_sync_reg[1];
    end
  end

  assign sck_rise  = pin_sync_reg[0] && !sck_prev_reg && !pin_sync_reg[1];
  assign cs_fall   = !pin_sync_reg[1] && cs_prev_reg;
  assign cs_rise   = pin_sync_reg[1] && !cs_prev_reg;
  assign si_bit    = pin_sync_reg[2];
  assign byte_next = {shift_reg, si_bit};

  function automatic sfcd_cmd_t mk(input logic [7:0] op, input sfcd_family_t fam,
                                   input sfcd_addr_t ad, input logic [7:0] mhz);
    sfcd_cmd_t c;
    c.opcode  = op;
    c.family  = fam;
    c.addr    = ad;
    c.max_mhz = mhz;
    return c;
  endfunction : mk

  function automatic sfcd_cmd_t decode(input logic [7:0] op);
    sfcd_cmd_t c;
    c = mk(op, FAM_NONE, ADDR_NONE, MHZ_133);
    case (op)
      OP_READ:        c = mk(op, FAM_READ, ADDR_3OR4, MHZ_50);
      OP_READ_4B:     c = mk(op, FAM_READ, ADDR_4, MHZ_50);
      OP_FAST:        c = mk(op, FAM_FAST, ADDR_3OR4, MHZ_133);
      OP_FAST_4B:     c = mk(op, FAM_FAST, ADDR_4, MHZ_133);
      OP_DDR_FAST:    c = mk(op, FAM_DDR, ADDR_3OR4, MHZ_80);
      OP_DDR_FAST_4B: c = mk(op, FAM_DDR, ADDR_4, MHZ_80);
      OP_PROG:        c = mk(op, FAM_PROG, ADDR_3OR4, MHZ_133);
      OP_PROG_4B:     c = mk(op, FAM_PROG, ADDR_4, MHZ_133);
      OP_QPROG_A:     c = mk(op, FAM_QPROG, ADDR_3OR4, MHZ_80);
      OP_QPROG_B:     c = mk(op, FAM_QPROG, ADDR_3OR4, MHZ_80);
      OP_QPROG_4B:    c = mk(op, FAM_QPROG, ADDR_4, MHZ_80);
      OP_DUAL_OUT:    c = mk(op, FAM_DUAL, ADDR_3OR4, MHZ_104);
      OP_DUAL_OUT_4B: c = mk(op, FAM_DUAL, ADDR_4, MHZ_104);
      OP_WRITE_REGS:  c = mk(op, FAM_REG_WR, ADDR_NONE, MHZ_133);
      OP_WRITE_EN:    c = mk(op, FAM_WEN, ADDR_NONE, MHZ_133);
      OP_WRITE_DIS:   c = mk(op, FAM_WDIS, ADDR_NONE, MHZ_133);
      OP_READ_ST1:    c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_READ_ST2:    c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_READ_CFG1:   c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_CLEAR_ST:    c = mk(op, FAM_CLEAR, ADDR_NONE, MHZ_133);
      OP_BOOT_RD:     c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_BOOT_WR:     c = mk(op, FAM_REG_WR, ADDR_NONE, MHZ_133);
      OP_BANK_RD:     c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_BANK_WR:     c = mk(op, FAM_REG_WR, ADDR_NONE, MHZ_133);
      OP_ECC_RD:      c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_PROT_RD:     c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_PROT_PROG:   c = mk(op, FAM_REG_WR, ADDR_NONE, MHZ_133);
      OP_PATTERN_RD:  c = mk(op, FAM_REG_RD, ADDR_NONE, MHZ_133);
      OP_OTP_PROG:    c = mk(op, FAM_PROG, ADDR_3OR4, MHZ_133);
      OP_PROG_SUSP:   c = mk(op, FAM_PSUSP, ADDR_NONE, MHZ_133);
      OP_ERASE_SUSP:  c = mk(op, FAM_ESUSP, ADDR_NONE, MHZ_133);
      OP_PROG_RES:    c = mk(op, FAM_PRES, ADDR_NONE, MHZ_133);
      OP_ERASE_RES:   c = mk(op, FAM_ERES, ADDR_NONE, MHZ_133);
      OP_MODE_RESET:  c = mk(op, FAM_MODE_RST, ADDR_NONE, MHZ_133);
      default:        c = mk(op, FAM_NONE, ADDR_NONE, MHZ_133);
    endcase
    return c;
  endfunction : decode

  assign cmd_next = decode(byte_next);

  // Frame sequencing
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else if (cs_rise) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cs_fall) begin
            state_reg <= cont_mode_reg ? ST_CONT : ST_OPCODE;
          end
        end
        ST_OPCODE: begin
          if (sck_rise && bit_cnt_reg == BIT_LAST) begin
            state_reg <= (cmd_next.family == FAM_NONE) ? ST_IGNORE : ST_PASS;
          end
        end
        ST_CONT: begin
          if (sck_rise && bit_cnt_reg == BIT_LAST) begin
            state_reg <= (byte_next == OP_MODE_RESET) ? ST_IGNORE : ST_PASS;
          end
        end
        ST_PASS: state_reg <= ST_PASS;
        ST_IGNORE: state_reg <= ST_IGNORE;
      endcase
    end
  end

  // Bit collection on serial clock rises
  always_ff @(posedge core_clk) begin
    if (srst || cs_fall) begin
      bit_cnt_reg <= BIT_FIRST;
      shift_reg   <= '0;
    end else if (sck_rise && (state_reg == ST_OPCODE || state_reg == ST_CONT)) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      shift_reg   <= byte_next[6:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || cs_fall) begin
      extra_reg <= 1'b0;
    end else if ((sck_rise && state_reg == ST_PASS) || state_reg == ST_CONT) begin
      // A continuous read frame never commits a stale one-byte command
      extra_reg <= 1'b1;
    end
  end

  // Continuous read mode; the escape wins over a same-cycle entry
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cont_mode_reg <= 1'b0;
    end else if (state_reg == ST_CONT && sck_rise && bit_cnt_reg == BIT_LAST
                 && byte_next == OP_MODE_RESET) begin
      cont_mode_reg <= 1'b0;
    end else if (cont_read_enter) begin
      cont_mode_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_reg       <= mk(OP_MODE_RESET, FAM_NONE, ADDR_NONE, MHZ_133);
      cmd_valid_reg <= 1'b0;
      mode_rst_reg  <= 1'b0;
    end else begin
      cmd_valid_reg <= 1'b0;
      mode_rst_reg  <= 1'b0;
      if (sck_rise && bit_cnt_reg == BIT_LAST) begin
        if (state_reg == ST_OPCODE && cmd_next.family != FAM_NONE) begin
          cmd_reg       <= cmd_next;
          cmd_valid_reg <= 1'b1;
          mode_rst_reg  <= (cmd_next.family == FAM_MODE_RST);
        end else if (state_reg == ST_CONT) begin
          mode_rst_reg <= (byte_next == OP_MODE_RESET);
        end
      end
    end
  end

  // One-byte commands take effect when chip select rises right after the byte
  assign commit_now = cs_rise && state_reg == ST_PASS && !extra_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= commit_now;
    end
  end

  // Suspend handling
  assign tmr_load = commit_now && (
      (cmd_reg.family == FAM_PSUSP && prog_busy && !psusp_pend_reg && !psusp_reg) ||
      (cmd_reg.family == FAM_ESUSP && erase_busy && !esusp_pend_reg && !esusp_reg
       && !psusp_pend_reg));
  // Count short so the flag clears within the limit measured from the pin edge
  assign tmr_val = (cmd_reg.family == FAM_PSUSP) ? TMR_W'(PSL_CYC - SUSP_LEAD)
                                                 : TMR_W'(ESL_CYC - SUSP_LEAD);
  assign susp_abort = alg_paused && (psusp_pend_reg || esusp_pend_reg);

  sfcd_latency_timer u_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .abort    (susp_abort),
    .done     (tmr_done)
  );

  always_ff @(posedge core_clk) begin
    if (srst || !prog_busy) begin
      psusp_pend_reg <= 1'b0;
      psusp_reg      <= 1'b0;
    end else if (tmr_load && cmd_reg.family == FAM_PSUSP) begin
      psusp_pend_reg <= 1'b1;
    end else if (psusp_pend_reg && (tmr_done || alg_paused)) begin
      psusp_pend_reg <= 1'b0;
      psusp_reg      <= 1'b1;
    end else if (commit_now && cmd_reg.family == FAM_PRES) begin
      psusp_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !erase_busy) begin
      esusp_pend_reg <= 1'b0;
      esusp_reg      <= 1'b0;
    end else if (tmr_load && cmd_reg.family == FAM_ESUSP) begin
      esusp_pend_reg <= 1'b1;
    end else if (esusp_pend_reg && (tmr_done || alg_paused)) begin
      esusp_pend_reg <= 1'b0;
      esusp_reg      <= 1'b1;
    end else if (commit_now && cmd_reg.family == FAM_ERES) begin
      esusp_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wip_reg <= 1'b0;
    end else begin
      wip_reg <= (prog_busy && !psusp_reg) || (erase_busy && !esusp_reg);
    end
  end

  assign cmd                    = cmd_reg;
  assign cmd_valid              = cmd_valid_reg;
  assign cmd_commit             = commit_reg;
  assign mode_bit_reset_cmd     = mode_rst_reg;
  assign cont_read_active       = cont_mode_reg;
  assign prog_suspend_req       = psusp_pend_reg || psusp_reg;
  assign erase_suspend_req      = esusp_pend_reg || esusp_reg;
  assign write_in_progress_flag = wip_reg;

  a_mode_rst_exit: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_CONT && sck_rise && bit_cnt_reg == BIT_LAST && byte_next == OP_MODE_RESET)
    |=> !cont_mode_reg && mode_rst_reg && state_reg == ST_IGNORE)
    else $error("mode bit reset did not leave continuous read");

  a_psl_limit: assert property (@(posedge core_clk) disable iff (srst)
    ($rose(psusp_pend_reg) && !erase_busy) |-> ##[1:C_PSL] !wip_reg)
    else $error("program suspend latency exceeded");

  a_esl_limit: assert property (@(posedge core_clk) disable iff (srst)
    ($rose(esusp_pend_reg) && !prog_busy) |-> ##[1:C_ESL] !wip_reg)
    else $error("erase suspend latency exceeded");

  a_read_decode: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_valid_reg && (cmd_reg.opcode == OP_READ || cmd_reg.opcode == OP_READ_4B))
    |-> cmd_reg.family == FAM_READ && cmd_reg.max_mhz == MHZ_50)
    else $error("normal read misdecoded");

  a_fast_decode: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_valid_reg && cmd_reg.opcode == OP_FAST_4B)
    |-> cmd_reg.family == FAM_FAST && cmd_reg.addr == ADDR_4 && cmd_reg.max_mhz == MHZ_133)
    else $error("fast read misdecoded");

  a_qprog_decode: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_valid_reg && cmd_reg.family == FAM_QPROG) |-> cmd_reg.max_mhz == MHZ_80)
    else $error("quad program ceiling wrong");

  a_dual_decode: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_valid_reg && cmd_reg.opcode == OP_DUAL_OUT_4B)
    |-> cmd_reg.family == FAM_DUAL && cmd_reg.addr == ADDR_4 && cmd_reg.max_mhz == MHZ_104)
    else $error("dual output read misdecoded");

  a_wip_busy: assert property (@(posedge core_clk) disable iff (srst)
    (!prog_busy && !erase_busy) [*2] |-> !write_in_progress_flag)
    else $error("busy flag set while idle");

  a_ignore_hold: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_IGNORE && !cs_rise) |=> state_reg == ST_IGNORE && !cmd_valid_reg)
    else $error("ignored frame produced a command");

  c_mode_rst_exit: cover property (@(posedge core_clk) disable iff (srst)
    cont_mode_reg ##1 !cont_mode_reg);
  c_prog_susp: cover property (@(posedge core_clk) disable iff (srst)
    psusp_pend_reg ##1 psusp_reg);
  c_erase_susp: cover property (@(posedge core_clk) disable iff (srst)
    esusp_pend_reg ##1 esusp_reg);
  c_read_cmd: cover property (@(posedge core_clk) disable iff (srst)
    cmd_valid_reg && cmd_reg.family == FAM_READ);

endmodule : sfcd_decoder

/* File: sfcd_host_model.sv */
/*
  Behavioural SPI host that sends instruction frames to the decoder.
  Assumes the decoder samples on the rising serial clock, mode 0, and that
  requests change only just after a rising core clock edge.
*/
`timescale 1ns/100ps
module sfcd_host_model (
  input  wire logic core_clk,
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_io0
);
  // Core cycles per half serial clock, giving an 800 ns serial period
  localparam int HALF = 4;

  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_io0  = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  task automatic shift(input logic [15:0] w, input int n);
    wait_cyc(1);
    spi_cs_n <= 1'b0;
    wait_cyc(HALF);
    for (int i = 15; i > 15 - n; i--) begin
      spi_io0 <= w[i];
      wait_cyc(HALF);
      spi_sck <= 1'b1;
      wait_cyc(HALF);
      spi_sck <= 1'b0;
    end
    wait_cyc(HALF);
    spi_cs_n <= 1'b1;
    // Released line shows the inverse of the last bit
    spi_io0  <= ~spi_io0;
    wait_cyc(2 * HALF);
  endtask : shift

  task automatic send4(input logic [3:0] b);
    shift({b, 12'h000}, 4);
  endtask : send4

  task automatic send8(input logic [7:0] b);
    shift({b, 8'h00}, 8);
  endtask : send8

  task automatic send16(input logic [15:0] w);
    shift(w, 16);
  endtask : send16
endmodule : sfcd_host_model

/* File: sfcd_decoder_tb.sv */
/*
  Self-checking testbench for the serial flash command decoder.
  Assumes the host model drives the link and the bench drives the engines.
*/
`timescale 1ns/100ps
module sfcd_decoder_tb;
  import sfcd_pkg::*;
  typedef struct packed {
    logic [7:0]   op;
    sfcd_family_t fam;
    sfcd_addr_t   ad;
    logic [7:0]   mhz;
    logic         chkf;
  } sfcd_row_t;

  logic      core_clk, srst, cont_read_enter, prog_busy, erase_busy, alg_paused;
  logic      spi_sck, spi_cs_n, spi_io0;
  logic      cmd_valid, cmd_commit, mode_bit_reset_cmd, cont_read_active;
  logic      prog_suspend_req, erase_suspend_req, write_in_progress_flag;
  sfcd_cmd_t cmd, got_cmd, e, g;
  int        err_count, num_checks, n_valid, n_commit, n_mode_rst, lat;
  sfcd_row_t rows [29] = '{
    '{8'h01,FAM_REG_WR,ADDR_NONE,MHZ_133,1'b1}, '{8'h02,FAM_PROG,ADDR_3OR4,MHZ_133,1'b1},
    '{8'h03,FAM_READ,ADDR_3OR4,MHZ_50,1'b1}, '{8'h04,FAM_WDIS,ADDR_NONE,MHZ_133,1'b1},
    '{8'h05,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1}, '{8'h06,FAM_WEN,ADDR_NONE,MHZ_133,1'b1},
    '{8'h07,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1}, '{8'h0B,FAM_FAST,ADDR_3OR4,MHZ_133,1'b1},
    '{8'h0C,FAM_FAST,ADDR_4,MHZ_133,1'b1}, '{8'h0D,FAM_DDR,ADDR_3OR4,MHZ_80,1'b1},
    '{8'h0E,FAM_DDR,ADDR_4,MHZ_80,1'b1}, '{8'h12,FAM_PROG,ADDR_4,MHZ_133,1'b1},
    '{8'h13,FAM_READ,ADDR_4,MHZ_50,1'b1}, '{8'h14,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1},
    '{8'h15,FAM_REG_WR,ADDR_NONE,MHZ_133,1'b1}, '{8'h16,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1},
    '{8'h17,FAM_REG_WR,ADDR_NONE,MHZ_133,1'b1}, '{8'h18,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1},
    '{8'h2B,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1}, '{8'h2F,FAM_REG_WR,ADDR_NONE,MHZ_133,1'b1},
    '{8'h30,FAM_CLEAR,ADDR_NONE,MHZ_133,1'b1}, '{8'h32,FAM_QPROG,ADDR_3OR4,MHZ_80,1'b1},
    '{8'h34,FAM_QPROG,ADDR_4,MHZ_80,1'b1}, '{8'h35,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1},
    '{8'h38,FAM_QPROG,ADDR_3OR4,MHZ_80,1'b1}, '{8'h3B,FAM_DUAL,ADDR_3OR4,MHZ_104,1'b1},
    '{8'h3C,FAM_DUAL,ADDR_4,MHZ_104,1'b1}, '{8'h41,FAM_REG_RD,ADDR_NONE,MHZ_133,1'b1},
    '{8'h42,FAM_PROG,ADDR_3OR4,MHZ_133,1'b1}};

  sfcd_host_model u_sfcd_host_model (.core_clk(core_clk), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_io0(spi_io0));
  sfcd_decoder u_sfcd_decoder (.core_clk(core_clk), .srst(srst), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_io0(spi_io0), .cont_read_enter(cont_read_enter),
    .prog_busy(prog_busy), .erase_busy(erase_busy), .alg_paused(alg_paused), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_commit(cmd_commit), .mode_bit_reset_cmd(mode_bit_reset_cmd),
    .cont_read_active(cont_read_active), .prog_suspend_req(prog_suspend_req),
    .erase_suspend_req(erase_suspend_req), .write_in_progress_flag(write_in_progress_flag));

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // Pulse counters and suspend latency measure
  always @(posedge core_clk) begin
    if (cmd_valid === 1'b1) begin
      n_valid++;
      got_cmd = cmd;
    end
    if (cmd_commit === 1'b1) n_commit++;
    if (mode_bit_reset_cmd === 1'b1) n_mode_rst++;
    if ((prog_suspend_req | erase_suspend_req) === 1'b1 && write_in_progress_flag === 1'b1)
      lat++;
  end

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    err_count++;
    $display("wrong value at %0t: got %h exp %h", $time, got, exp);
  endtask : report

  task automatic chk_v(input sfcd_cmd_t got, input sfcd_cmd_t exp);
    num_checks++;
    if (got !== exp) report(32'(got), 32'(exp));
  endtask : chk_v

  task automatic chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) report(32'(got), 32'(exp));
  endtask : chk_b

  task automatic chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp) report(got, exp);
  endtask : chk_n

  task automatic clr();
    n_valid  = 0;
    n_commit = 0;
    n_mode_rst = 0;
  endtask : clr

  task automatic go8(input logic [7:0] b);
    clr();
    u_sfcd_host_model.send8(b);
    @(negedge core_clk);
  endtask : go8

  task automatic wait_idle(input int n);
    for (int i = 0; i < n && write_in_progress_flag !== 1'b0; i++) @(negedge core_clk);
  endtask : wait_idle

  task automatic pulse_cont();
    @(posedge core_clk);
    cont_read_enter <= 1'b1;
    @(posedge core_clk);
    cont_read_enter <= 1'b0;
    @(negedge core_clk);
  endtask : pulse_cont

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial begin
    {srst, cont_read_enter, prog_busy, erase_busy, alg_paused} = 5'h10;
    {err_count, num_checks, lat} = '0;
    clr();
    fork
      begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        conclude();
      end
    join_none
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    go8(OP_MODE_RESET);
    chk_n(n_mode_rst, 1);
    foreach (rows[i]) begin
      go8(rows[i].op);
      e = '{rows[i].op, rows[i].fam, rows[i].ad, rows[i].mhz};
      g = got_cmd;
      if (!rows[i].chkf) begin
        g.family = FAM_NONE;
        g.addr   = ADDR_NONE;
      end
      chk_n(n_valid + n_commit, 2);
      chk_v(g, e);
    end
    // Unknown opcode followed by a known byte in the same frame
    clr();
    u_sfcd_host_model.send16(16'hE506);
    @(negedge core_clk);
    chk_n(n_valid + n_commit, 0);
    // Known opcode with trailing bits: decoded but not committed
    clr();
    u_sfcd_host_model.send16(16'h0306);
    @(negedge core_clk);
    chk_n(n_valid * 2 + n_commit, 2);
    clr();
    u_sfcd_host_model.send4(4'h0);
    u_sfcd_host_model.send8(OP_WRITE_EN);
    @(negedge core_clk);
    chk_n(n_valid, 1);
    chk_v(got_cmd, '{8'h06, FAM_WEN, ADDR_NONE, MHZ_133});
    // Continuous read and its escape
    pulse_cont();
    chk_b(cont_read_active, 1'b1);
    go8(OP_READ);
    chk_n(n_valid, 0);
    chk_n(n_commit, 0);
    go8(OP_MODE_RESET);
    chk_n(n_mode_rst, 1);
    chk_b(cont_read_active, 1'b0);
    go8(OP_FAST);
    chk_n(n_valid, 1);
    // Program suspend, resume, early halt
    @(posedge core_clk) prog_busy <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk_b(write_in_progress_flag, 1'b1);
    lat = 0;
    go8(OP_PROG_SUSP);
    wait_idle(600);
    chk_b(prog_suspend_req, 1'b1);
    chk_n(int'(write_in_progress_flag === 1'b0 && lat <= PSL_CYC), 1);
    go8(OP_PROG_RES);
    chk_b(write_in_progress_flag, 1'b1);
    go8(OP_PROG_SUSP);
    @(posedge core_clk) alg_paused <= 1'b1;
    @(posedge core_clk);
    alg_paused <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk_b(write_in_progress_flag, 1'b0);
    @(posedge core_clk) prog_busy <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk_b(prog_suspend_req | write_in_progress_flag, 1'b0);
    // Erase suspend and resume
    @(posedge core_clk) erase_busy <= 1'b1;
    lat = 0;
    go8(OP_ERASE_SUSP);
    wait_idle(600);
    chk_b(erase_suspend_req, 1'b1);
    chk_n(int'(write_in_progress_flag === 1'b0 && lat <= ESL_CYC), 1);
    go8(OP_ERASE_RES);
    chk_b(write_in_progress_flag, 1'b1);
    @(posedge core_clk) erase_busy <= 1'b0;
    // Reset in mid-run while in continuous read
    pulse_cont();
    @(posedge core_clk) srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk_v(cmd, '{8'hFF, FAM_NONE, ADDR_NONE, MHZ_133});
    chk_b(cont_read_active | write_in_progress_flag, 1'b0);
    @(posedge core_clk) srst <= 1'b0;
    repeat (4) @(negedge core_clk);
    go8(OP_READ_ST1);
    chk_n(n_valid + n_commit, 2);
    conclude();
  end
endmodule : sfcd_decoder_tb
